// [rtl/agc_ctrl.sv]
// Top of the ADC gain, offset and calibration control block with its register port.
//
// What this block and the software that drives it do
// R1: Gain code in low three bits of control zero selects 1 to 128.
// R2: Offset DAC byte is sign in top bit, magnitude in low seven.
// R3: Software writes the offset DAC only after calibration has finished.
// R4: Modulator sample rate is clock divided by divider plus one, then 64.
// R5: One result per decimation ratio samples; ratio from low and high bytes.
// R6: Calibration field codes: none, self both, self offset, self gain, system offset, gain.
// R7: Each calibration step lasts seven data periods; combined self mode fourteen.
// R8: System offset uses external zero input; stored correction cancels offset.
// R9: System gain uses external full-scale input; stored correction cancels gain error.
// R10: Writing a calibration code from 1 to 5 starts that calibration.
// R11: Completion sets conversion flag bit 5 of status; interrupt when unmasked.
// R12: Software should calibrate after power-up, temperature change and gain change.
// R13: Software keeps the input buffer off during calibration at high reference.
// R14: Reading the conversion result clears the pending conversion flag.
// R15: Buffer enable bit 3 of control zero switches the input buffer.
// R16: Reserved calibration codes start nothing, stop a running calibration and raise no flag.
`timescale 1ns/1ps
`include "agc_map.svh"
module agc_ctrl #(
  parameter int RES_W = 24,
  parameter int DEC_W = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Special function register port
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrEn,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrRdEn,
  output logic [7:0] sfrRdData,
  // Filter result and interrupt mask
  input wire logic filterValid,
  input wire logic signed [RES_W-1:0] filterResult,
  input wire logic resultRead,
  input wire logic irqMaskEnable,
  // Analog front end controls
  output logic [2:0] gainSelect,
  output logic [7:0] gainFactor,
  output logic bufferEnable,
  output logic odacNegative,
  output logic [6:0] odacMagnitude,
  output logic modulatorSampleEn,
  output logic dataPeriodTick,
  // Calibration
  output agc_pkg::agc_cal_src_t calSource,
  output logic calBusy,
  output logic signed [RES_W-1:0] offsetCorrection,
  output logic signed [RES_W-1:0] gainCorrection,
  // Status
  output logic adcConversionFlag,
  output logic adc_conversion_flag
);

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  logic [7:0] ctl0_q, ctl0_d, ctl1_q, ctl1_d, decLo_q, decLo_d, decHi_q, decHi_d;
  logic [7:0] input_offset_dac_q, input_offset_dac_d, aclk_q, aclk_d, rd_q, rd_d;
  logic flag_q, flag_d, irq_q, irq_d;
  logic calStart;
  agc_pkg::agc_cal_mode_t calMode;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction

  // Only defined codes start a run; reserved codes are stored but start nothing.
  assign calMode = agc_pkg::agc_cal_mode_t'(sfrWrData[`AGC_CAL_MSB:`AGC_CAL_LSB]);
  assign calStart = sfrWrEn && hit(sfrAddr, `AGC_ADDR_CTL1)
    && calMode != agc_pkg::AGC_CAL_NONE; // R10

  always_comb begin
    ctl0_d = ctl0_q;
    ctl1_d = ctl1_q;
    decLo_d = decLo_q;
    decHi_d = decHi_q;
    input_offset_dac_d = input_offset_dac_q;
    aclk_d = aclk_q;
    if (sfrWrEn) begin
      if (hit(sfrAddr, `AGC_ADDR_CTL0)) ctl0_d = sfrWrData;
      if (hit(sfrAddr, `AGC_ADDR_CTL1)) ctl1_d = sfrWrData;
      if (hit(sfrAddr, `AGC_ADDR_DEC_LO)) decLo_d = sfrWrData;
      if (hit(sfrAddr, `AGC_ADDR_DEC_HI)) decHi_d = sfrWrData;
      if (hit(sfrAddr, `AGC_ADDR_INPUT_OFFSET_DAC)) input_offset_dac_d = sfrWrData;
      if (hit(sfrAddr, `AGC_ADDR_ACLK)) aclk_d = sfrWrData;
    end
    rd_d = `AGC_RD_IDLE;
    if (sfrRdEn) begin
      case (sfrAddr)
        `AGC_ADDR_IRQ_STATUS: rd_d[`AGC_FLAG_BIT] = flag_q; // R11
        `AGC_ADDR_CTL0: rd_d = ctl0_q;
        `AGC_ADDR_CTL1: rd_d = ctl1_q;
        `AGC_ADDR_DEC_LO: rd_d = decLo_q;
        `AGC_ADDR_DEC_HI: rd_d = decHi_q;
        `AGC_ADDR_INPUT_OFFSET_DAC: rd_d = input_offset_dac_q;
        `AGC_ADDR_ACLK: rd_d = aclk_q;
        default: rd_d = `AGC_RD_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Conversion flag and front end outputs
  // --------------------------------------------------------------------------
  logic [2:0] gainSel_q, gainSel_d;
  logic [7:0] gainFac_q, gainFac_d;
  logic buf_q, buf_d, odacNeg_q, odacNeg_d;
  logic [6:0] odacMag_q, odacMag_d;
  logic calDone;
  logic calBusyInt;
  logic flagSet;

  // Results produced while calibrating are not reported; only the finish is.
  assign flagSet = calDone || (filterValid && !calBusyInt && !calStart);

  always_comb begin
    flag_d = flag_q;
    if (resultRead) flag_d = 1'b0; // R14
    if (flagSet) flag_d = 1'b1; // R11
    irq_d = flag_d && irqMaskEnable; // R11
    gainSel_d = ctl0_q[`AGC_GAIN_MSB:`AGC_GAIN_LSB]; // R1
    gainFac_d = 8'h01 << ctl0_q[`AGC_GAIN_MSB:`AGC_GAIN_LSB]; // R1
    buf_d = ctl0_q[`AGC_BUF_BIT]; // R15
    odacNeg_d = input_offset_dac_q[`AGC_INPUT_OFFSET_DAC_SIGN]; // R2
    odacMag_d = input_offset_dac_q[`AGC_INPUT_OFFSET_DAC_MAG_MSB:0]; // R2
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctl0_q <= `AGC_RST_CTL0;
      ctl1_q <= `AGC_RST_ZERO;
      decLo_q <= `AGC_RST_ZERO;
      decHi_q <= `AGC_RST_ZERO;
      input_offset_dac_q <= `AGC_RST_ZERO;
      aclk_q <= `AGC_RST_ZERO;
      rd_q <= `AGC_RD_IDLE;
      flag_q <= 1'b0;
      irq_q <= 1'b0;
      gainSel_q <= 3'h0;
      gainFac_q <= 8'h01;
      buf_q <= 1'b0;
      odacNeg_q <= 1'b0;
      odacMag_q <= 7'h00;
    end else begin
      ctl0_q <= ctl0_d;
      ctl1_q <= ctl1_d;
      decLo_q <= decLo_d;
      decHi_q <= decHi_d;
      input_offset_dac_q <= input_offset_dac_d;
      aclk_q <= aclk_d;
      rd_q <= rd_d;
      flag_q <= flag_d;
      irq_q <= irq_d;
      gainSel_q <= gainSel_d;
      gainFac_q <= gainFac_d;
      buf_q <= buf_d;
      odacNeg_q <= odacNeg_d;
      odacMag_q <= odacMag_d;
    end
  end

  // --------------------------------------------------------------------------
  // Rate generation and calibration
  // --------------------------------------------------------------------------
  agc_tick_if #(.DIV_W(8), .DEC_W(DEC_W)) tick ();

  assign tick.clkDivider = aclk_q; // R4
  assign tick.decimRatio = DEC_W'({decHi_q, decLo_q}); // R5

  agc_rate_gen #(.DIV_W(8), .DEC_W(DEC_W)) u_rate (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .tick(tick.src)
  );

  agc_cal_seq #(.RES_W(RES_W)) u_cal (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .tick(tick.snk),
    .start(calStart),
    .startMode(calMode),
    .sampleValid(filterValid),
    .sampleValue(filterResult),
    .busy(calBusyInt),
    .done(calDone),
    .calSrc(calSource),
    .offsetCorr(offsetCorrection),
    .gainCorr(gainCorrection)
  );

  assign sfrRdData = rd_q;
  assign gainSelect = gainSel_q;
  assign gainFactor = gainFac_q;
  assign bufferEnable = buf_q;
  assign odacNegative = odacNeg_q;
  assign odacMagnitude = odacMag_q;
  assign modulatorSampleEn = tick.modTick;
  assign dataPeriodTick = tick.dataTick;
  assign calBusy = calBusyInt;
  assign adcConversionFlag = flag_q;
  assign adc_conversion_flag = irq_q;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  property p_gain_decode;
    @(posedge ref_clk) disable iff (!rstn)
      sfrWrEn && hit(sfrAddr, `AGC_ADDR_CTL0)
      |=> ##1 gainFac_q == (8'h01 << $past(sfrWrData[`AGC_GAIN_MSB:`AGC_GAIN_LSB], 2));
  endproperty
  a_gain_decode: assert property (p_gain_decode) else $error("Gain factor wrong."); // R1

  property p_input_offset_dac_split;
    @(posedge ref_clk) disable iff (!rstn)
      sfrWrEn && hit(sfrAddr, `AGC_ADDR_INPUT_OFFSET_DAC)
      |=> ##1 odacNeg_q == $past(sfrWrData[`AGC_INPUT_OFFSET_DAC_SIGN], 2)
      && odacMag_q == $past(sfrWrData[`AGC_INPUT_OFFSET_DAC_MAG_MSB:0], 2);
  endproperty
  a_input_offset_dac_split: assert property (p_input_offset_dac_split) else $error("Offset DAC split wrong."); // R2

  property p_buf_follow;
    @(posedge ref_clk) disable iff (!rstn)
      sfrWrEn && hit(sfrAddr, `AGC_ADDR_CTL0) |=> ##1 buf_q == $past(sfrWrData[`AGC_BUF_BIT], 2);
  endproperty
  a_buf_follow: assert property (p_buf_follow) else $error("Buffer enable wrong."); // R15

  property p_cal_start;
    @(posedge ref_clk) disable iff (!rstn)
      calStart && calMode < agc_pkg::AGC_CAL_RSV6 |=> calBusyInt;
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("Calibration did not start."); // R10

  property p_done_flag;
    @(posedge ref_clk) disable iff (!rstn)
      calDone |=> flag_q ##1 (irq_q == (flag_q && $past(irqMaskEnable)));
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("Completion not flagged."); // R11

  property p_read_clear;
    @(posedge ref_clk) disable iff (!rstn)
      resultRead && !flagSet |=> !flag_q;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("Read did not clear flag."); // R14

endmodule

// [shared/agc_map.svh]
// Register addresses, field positions, reset values and counts of the ADC control block.
`ifndef AGC_MAP_SVH
`define AGC_MAP_SVH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define AGC_ADDR_IRQ_STATUS 8'hA7
`define AGC_ADDR_CTL0 8'hDC
`define AGC_ADDR_CTL1 8'hDD
`define AGC_ADDR_DEC_LO 8'hDE
`define AGC_ADDR_DEC_HI 8'hDF
`define AGC_ADDR_INPUT_OFFSET_DAC 8'hE6
`define AGC_ADDR_ACLK 8'hF6

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define AGC_GAIN_MSB 2
`define AGC_GAIN_LSB 0
`define AGC_BUF_BIT 3
`define AGC_CAL_MSB 2
`define AGC_CAL_LSB 0
`define AGC_FLAG_BIT 5
`define AGC_INPUT_OFFSET_DAC_SIGN 7
`define AGC_INPUT_OFFSET_DAC_MAG_MSB 6

// ----------------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------------
`define AGC_RST_CTL0 8'h30
`define AGC_RST_ZERO 8'h00
`define AGC_RD_IDLE 8'h00
`define AGC_MOD_PRESCALE 64
`define AGC_CAL_STEP_PERIODS 7

`endif

// [shared/agc_pkg.sv]
// Types shared by the ADC control block.
package agc_pkg;

  typedef enum logic [2:0] {
    AGC_CAL_NONE,
    AGC_CAL_SELF_BOTH,
    AGC_CAL_SELF_OFS,
    AGC_CAL_SELF_GAIN,
    AGC_CAL_SYS_OFS,
    AGC_CAL_SYS_GAIN,
    AGC_CAL_RSV6,
    AGC_CAL_RSV7
  } agc_cal_mode_t;

  typedef enum logic [1:0] {
    AGC_ST_IDLE,
    AGC_ST_OFFSET,
    AGC_ST_GAIN
  } agc_cal_state_t;

  typedef enum logic [1:0] {
    AGC_SRC_EXTERNAL,
    AGC_SRC_INT_ZERO,
    AGC_SRC_INT_REF
  } agc_cal_src_t;

endpackage

// [shared/agc_tick_if.sv]
// Rate settings and sample/data ticks passed between the block's modules.
`timescale 1ns/1ps
interface agc_tick_if #(parameter int DIV_W = 8, parameter int DEC_W = 16);
  logic [DIV_W-1:0] clkDivider;
  logic [DEC_W-1:0] decimRatio;
  logic modTick;
  logic dataTick;

  modport src (input clkDivider, input decimRatio, output modTick, output dataTick);
  modport snk (input modTick, input dataTick);
endinterface

// [rtl/agc_rate_gen.sv]
// Modulator sample enable and output data period enable dividers.
`timescale 1ns/1ps
`include "agc_map.svh"
module agc_rate_gen #(
  parameter int DIV_W = 8,
  parameter int DEC_W = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Rate settings and ticks
  agc_tick_if.src tick
);

  localparam int PRE_W = $clog2(`AGC_MOD_PRESCALE);

  logic [DIV_W-1:0] divCnt_q, divCnt_d;
  logic [PRE_W-1:0] preCnt_q, preCnt_d;
  logic [DEC_W-1:0] decCnt_q, decCnt_d;
  logic modTick_q, modTick_d;
  logic dataTick_q, dataTick_d;
  logic [DEC_W-1:0] ratioEff;
  logic divEnd;
  logic modEnd;

  // A zero ratio would wrap to the longest possible period, so it behaves as one.
  assign ratioEff = (tick.decimRatio == '0) ? DEC_W'(1) : tick.decimRatio;
  assign divEnd = (divCnt_q >= tick.clkDivider);
  assign modEnd = divEnd && (preCnt_q == PRE_W'(`AGC_MOD_PRESCALE - 1));

  always_comb begin
    divCnt_d = divEnd ? '0 : divCnt_q + DIV_W'(1); // R4
    preCnt_d = preCnt_q;
    if (divEnd) begin
      preCnt_d = preCnt_q + PRE_W'(1); // R4
    end
    decCnt_d = decCnt_q;
    dataTick_d = 1'b0;
    if (modEnd) begin
      if (decCnt_q >= ratioEff - DEC_W'(1)) begin
        decCnt_d = '0;
        dataTick_d = 1'b1; // R5
      end else begin
        decCnt_d = decCnt_q + DEC_W'(1);
      end
    end
    modTick_d = modEnd;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      divCnt_q <= '0;
      preCnt_q <= '0;
      decCnt_q <= '0;
      modTick_q <= 1'b0;
      dataTick_q <= 1'b0;
    end else begin
      divCnt_q <= divCnt_d;
      preCnt_q <= preCnt_d;
      decCnt_q <= decCnt_d;
      modTick_q <= modTick_d;
      dataTick_q <= dataTick_d;
    end
  end

  assign tick.modTick = modTick_q;
  assign tick.dataTick = dataTick_q;

  property p_mod_rate;
    @(posedge ref_clk) disable iff (!rstn)
      modTick_q |-> $past(divEnd) && ($past(preCnt_q) == PRE_W'(`AGC_MOD_PRESCALE - 1));
  endproperty
  a_mod_rate: assert property (p_mod_rate) else $error("Modulator tick off its divide."); // R4

  property p_data_rate;
    @(posedge ref_clk) disable iff (!rstn)
      dataTick_q |-> modTick_q && (decCnt_q == '0);
  endproperty
  a_data_rate: assert property (p_data_rate) else $error("Data tick not on ratio end."); // R5

endmodule

// [rtl/agc_cal_seq.sv]
// Calibration sequencer: step timing, input source selection and stored corrections.
`timescale 1ns/1ps
`include "agc_map.svh"
module agc_cal_seq #(
  parameter int RES_W = 24
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Timing
  agc_tick_if.snk tick,
  // Start request
  input wire logic start,
  input agc_pkg::agc_cal_mode_t startMode,
  // Filtered result
  input wire logic sampleValid,
  input wire logic signed [RES_W-1:0] sampleValue,
  // Status and corrections
  output logic busy,
  output logic done,
  output agc_pkg::agc_cal_src_t calSrc,
  output logic signed [RES_W-1:0] offsetCorr,
  output logic signed [RES_W-1:0] gainCorr
);

  agc_pkg::agc_cal_state_t state_q, state_d;
  agc_pkg::agc_cal_mode_t mode_q, mode_d;
  agc_pkg::agc_cal_src_t src_q, src_d;
  logic [2:0] stepCnt_q, stepCnt_d;
  logic signed [RES_W-1:0] last_q, last_d, ofs_q, ofs_d, gain_q, gain_d;
  logic done_q, done_d, busy_q, busy_d;
  logic stepEnd;

  assign stepEnd = tick.dataTick && (stepCnt_q == 3'(`AGC_CAL_STEP_PERIODS - 1));

  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    src_d = src_q;
    stepCnt_d = stepCnt_q;
    last_d = sampleValid ? sampleValue : last_q;
    ofs_d = ofs_q;
    gain_d = gain_q;
    done_d = 1'b0;
    if (start) begin
      mode_d = startMode;
      stepCnt_d = '0;
      case (startMode) // R6
        agc_pkg::AGC_CAL_SELF_BOTH, agc_pkg::AGC_CAL_SELF_OFS: begin
          state_d = agc_pkg::AGC_ST_OFFSET;
          src_d = agc_pkg::AGC_SRC_INT_ZERO;
        end
        agc_pkg::AGC_CAL_SELF_GAIN: begin
          state_d = agc_pkg::AGC_ST_GAIN;
          src_d = agc_pkg::AGC_SRC_INT_REF;
        end
        agc_pkg::AGC_CAL_SYS_OFS: begin
          state_d = agc_pkg::AGC_ST_OFFSET; // R8
          src_d = agc_pkg::AGC_SRC_EXTERNAL;
        end
        agc_pkg::AGC_CAL_SYS_GAIN: begin
          state_d = agc_pkg::AGC_ST_GAIN; // R9
          src_d = agc_pkg::AGC_SRC_EXTERNAL;
        end
        default: begin
          state_d = agc_pkg::AGC_ST_IDLE; // R16
          src_d = agc_pkg::AGC_SRC_EXTERNAL;
        end
      endcase
    end else begin
      if (tick.dataTick && state_q != agc_pkg::AGC_ST_IDLE) begin
        stepCnt_d = stepEnd ? '0 : stepCnt_q + 3'(1); // R7
      end
      case (state_q)
        agc_pkg::AGC_ST_OFFSET: begin
          if (stepEnd) begin
            ofs_d = -last_d; // R8
            if (mode_q == agc_pkg::AGC_CAL_SELF_BOTH) begin
              state_d = agc_pkg::AGC_ST_GAIN; // R7
              src_d = agc_pkg::AGC_SRC_INT_REF;
            end else begin
              state_d = agc_pkg::AGC_ST_IDLE;
              src_d = agc_pkg::AGC_SRC_EXTERNAL;
              done_d = 1'b1;
            end
          end
        end
        agc_pkg::AGC_ST_GAIN: begin
          if (stepEnd) begin
            gain_d = last_d; // R9
            state_d = agc_pkg::AGC_ST_IDLE;
            src_d = agc_pkg::AGC_SRC_EXTERNAL;
            done_d = 1'b1;
          end
        end
        default: begin
          state_d = agc_pkg::AGC_ST_IDLE;
        end
      endcase
    end
    busy_d = (state_d != agc_pkg::AGC_ST_IDLE);
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= agc_pkg::AGC_ST_IDLE;
      mode_q <= agc_pkg::AGC_CAL_NONE;
      src_q <= agc_pkg::AGC_SRC_EXTERNAL;
      stepCnt_q <= '0;
      last_q <= '0;
      ofs_q <= '0;
      gain_q <= '0;
      done_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
      src_q <= src_d;
      stepCnt_q <= stepCnt_d;
      last_q <= last_d;
      ofs_q <= ofs_d;
      gain_q <= gain_d;
      done_q <= done_d;
      busy_q <= busy_d;
    end
  end

  assign busy = busy_q;
  assign done = done_q;
  assign calSrc = src_q;
  assign offsetCorr = ofs_q;
  assign gainCorr = gain_q;

  // Helper: data periods seen while busy since the last start.
  logic [4:0] periodCnt_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      periodCnt_q <= '0;
    end else if (start) begin
      periodCnt_q <= '0;
    end else if (busy && tick.dataTick) begin
      periodCnt_q <= periodCnt_q + 5'(1);
    end
  end

  property p_cal_length;
    @(posedge ref_clk) disable iff (!rstn)
      done_q |-> (periodCnt_q == ((mode_q == agc_pkg::AGC_CAL_SELF_BOTH) ?
        5'(2 * `AGC_CAL_STEP_PERIODS) : 5'(`AGC_CAL_STEP_PERIODS)));
  endproperty
  a_cal_length: assert property (p_cal_length) else $error("Calibration length wrong."); // R7

  property p_reserved_idle;
    @(posedge ref_clk) disable iff (!rstn)
      start && startMode >= agc_pkg::AGC_CAL_RSV6 |=> !busy ##1 !done_q;
  endproperty
  a_reserved_idle: assert property (p_reserved_idle) else $error("Reserved code ran."); // R16

  property p_reserved_keep;
    @(posedge ref_clk) disable iff (!rstn)
      start && startMode >= agc_pkg::AGC_CAL_RSV6 |=> $stable(ofs_q) && $stable(gain_q);
  endproperty
  a_reserved_keep: assert property (p_reserved_keep) else $error("Corrections changed."); // R16

endmodule

// [sim/agc_filter_model.sv]
// Far-side model: sensor inputs and the decimation filter that feeds the control block.
`timescale 1ns/1ps
module agc_filter_model #(
  parameter logic signed [23:0] ZERO_RD = 24'sh000123,
  parameter logic signed [23:0] REF_RD = 24'sh3FFF00
) (
  // Timing and source selection from the block
  input wire logic dataPeriodTick,
  input agc_pkg::agc_cal_src_t calSrc,
  // Level the bench applies at the external inputs
  input wire logic signed [23:0] sensor,
  // Filter output
  output logic filterValid,
  output logic signed [23:0] filterResult
);
  logic signed [23:0] level;

  // Internal zero and reference give fixed readings; otherwise the pins are measured.
  assign level = (calSrc == agc_pkg::AGC_SRC_INT_ZERO) ? ZERO_RD :
                  (calSrc == agc_pkg::AGC_SRC_INT_REF) ? REF_RD : sensor;
  // One result per output data period, and garbage between results.
  assign filterValid = dataPeriodTick;
  assign filterResult = filterValid ? level : ~level;
endmodule

// [sim/agc_ctrl_tb.sv]
// Self-checking testbench of the ADC gain, offset and calibration control block.
`timescale 1ns/1ps
`include "agc_map.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module agc_ctrl_tb;
  localparam logic signed [23:0] ZERO_RD = 24'sh000123;
  localparam logic signed [23:0] REF_RD = 24'sh3FFF00;
  localparam logic signed [23:0] SYS_OFS = 24'sh000456;
  localparam logic signed [23:0] SYS_FS = 24'sh3FF800;
  logic ref_clk, rstn, sfrWrEn, sfrRdEn, filterValid, resultRead, irqMaskEnable;
  logic [7:0] sfrAddr, sfrWrData, sfrRdData, gainFactor;
  logic signed [23:0] filterResult, sensor, offsetCorrection, gainCorrection, expOfs, expGain;
  logic [2:0] gainSelect;
  logic [6:0] odacMagnitude;
  logic bufferEnable, odacNegative, modulatorSampleEn, dataPeriodTick, calBusy;
  logic adcConversionFlag, adc_conversion_flag;
  agc_pkg::agc_cal_src_t calSource;
  int error_cnt = 0;
  int n_checks = 0;
  logic [31:0] rnd = 32'h6C7663EA;
  logic [7:0] stepTab [1:5] = '{8'h0E, 8'h07, 8'h07, 8'h07, 8'h07};
  logic [7:0] a [7] = '{8'hA7, 8'hDD, 8'hDE, 8'hDF, 8'hE6, 8'hF6, 8'h10};
  agc_pkg::agc_cal_src_t srcTab [1:5] = '{agc_pkg::AGC_SRC_INT_ZERO,
    agc_pkg::AGC_SRC_INT_ZERO, agc_pkg::AGC_SRC_INT_REF, agc_pkg::AGC_SRC_EXTERNAL,
    agc_pkg::AGC_SRC_EXTERNAL};

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  agc_filter_model #(.ZERO_RD(ZERO_RD), .REF_RD(REF_RD)) partner (
    .dataPeriodTick(dataPeriodTick), .calSrc(calSource), .sensor(sensor),
    .filterValid(filterValid), .filterResult(filterResult));

  agc_ctrl dut (
    .ref_clk(ref_clk), .rstn(rstn), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
    .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData),
    .filterValid(filterValid), .filterResult(filterResult), .resultRead(resultRead),
    .irqMaskEnable(irqMaskEnable), .gainSelect(gainSelect), .gainFactor(gainFactor),
    .bufferEnable(bufferEnable), .odacNegative(odacNegative), .odacMagnitude(odacMagnitude),
    .modulatorSampleEn(modulatorSampleEn), .dataPeriodTick(dataPeriodTick),
    .calSource(calSource), .calBusy(calBusy), .offsetCorrection(offsetCorrection),
    .gainCorrection(gainCorrection), .adcConversionFlag(adcConversionFlag), .adc_conversion_flag(adc_conversion_flag));

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfrAddr <= a;
    sfrWrData <= d;
    sfrWrEn <= 1'b1;
    @(posedge ref_clk);
    sfrWrEn <= 1'b0;
  endtask

  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    sfrAddr <= a;
    sfrRdEn <= 1'b1;
    @(posedge ref_clk);
    sfrRdEn <= 1'b0;
    #1 d = sfrRdData;
  endtask

  // Waits a bounded time for a pulse on the chosen strobe and returns while it is still high.
  task automatic wait_pulse(input bit tick, output int cyc);
    cyc = 0;
    do begin
      @(posedge ref_clk);
      #1 cyc++;
    end while (((tick ? dataPeriodTick : modulatorSampleEn) !== 1'b1) && cyc < 40000);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // The slowest stretch is one long data period of about 16.5k cycles.
  initial begin
    repeat (90000) @(posedge ref_clk);
    error_cnt++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    logic [7:0] rd;
    int cyc;
    int n;
    rstn = 1'b0;
    {sfrAddr, sfrWrEn, sfrWrData, sfrRdEn, resultRead, irqMaskEnable} = '0;
    sensor = SYS_OFS;
    expOfs = '0;
    expGain = '0;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    sfr_rd(`AGC_ADDR_CTL0, rd);
    `CHK("ctl0 reset", 8'h30, rd)
    `CHK("gain reset", 8'h01, gainFactor)
    foreach (a[i]) begin
      sfr_rd(a[i], rd);
      `CHK("reg reset", 8'h00, rd)
    end
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      rnd = lfsr(rnd);
      sfr_wr(`AGC_ADDR_CTL0, {rnd[7:3], 3'(c)});
      @(posedge ref_clk);
      #1 `CHK("gain code", 3'(c), gainSelect)
      `CHK("gain", 8'h01 << c, gainFactor)
      `CHK("buffer", rnd[3], bufferEnable)
    end
    $display("test gain done");
    sfr_wr(`AGC_ADDR_ACLK, 8'h01);
    sfr_wr(`AGC_ADDR_DEC_LO, 8'h02);
    sfr_wr(`AGC_ADDR_DEC_HI, 8'h01);
    wait_pulse(0, cyc);
    wait_pulse(0, cyc);
    `CHK("sample period", 128, cyc)
    sfr_wr(`AGC_ADDR_ACLK, 8'h00);
    wait_pulse(1, cyc);
    wait_pulse(1, cyc);
    `CHK("data period", 258 * 64, cyc)
    sfr_wr(`AGC_ADDR_DEC_HI, 8'h00);
    wait_pulse(1, cyc);
    wait_pulse(1, cyc);
    `CHK("short data period", 128, cyc)
    $display("test rates done");
    sfr_wr(`AGC_ADDR_CTL0, 8'h30);
    for (int m = 1; m <= 7; m++) begin
      sensor <= (m == 4) ? SYS_OFS : SYS_FS;
      irqMaskEnable <= (m != 3);
      wait_pulse(1, cyc);
      @(posedge ref_clk);
      resultRead <= 1'b1;
      @(posedge ref_clk);
      resultRead <= 1'b0;
      sfr_wr(`AGC_ADDR_CTL1, 8'(m));
      @(posedge ref_clk);
      #1 `CHK("busy", m < 6, calBusy)
      `CHK("buffer off", 1'b0, bufferEnable)
      if (m < 6) begin
        `CHK("source", srcTab[m], calSource)
        n = 0;
        cyc = 0;
        while (calBusy === 1'b1 && cyc < 40000) begin
          @(posedge ref_clk);
          #1 cyc++;
          if (dataPeriodTick === 1'b1 && calBusy === 1'b1) n++;
        end
        `CHK("steps", stepTab[m], 8'(n))
        if (m == 1 || m == 2 || m == 4) expOfs = -((m == 4) ? SYS_OFS : ZERO_RD);
        if (m == 1 || m == 3 || m == 5) expGain = (m == 5) ? SYS_FS : REF_RD;
        @(posedge ref_clk);
        #1 `CHK("done flag", 1'b1, adcConversionFlag)
        @(posedge ref_clk);
        #1 `CHK("irq", m != 3, adc_conversion_flag)
        sfr_rd(`AGC_ADDR_IRQ_STATUS, rd);
        `CHK("status", 8'h20, rd)
        @(posedge ref_clk);
        resultRead <= 1'b1;
        @(posedge ref_clk);
        resultRead <= 1'b0;
        @(posedge ref_clk);
        #1 `CHK("flag clear", 1'b0, adcConversionFlag)
      end else begin
        repeat (20) @(posedge ref_clk);
        #1 `CHK("reserved flag", 1'b0, adcConversionFlag)
      end
      `CHK("offset corr", expOfs, offsetCorrection)
      `CHK("gain corr", expGain, gainCorrection)
    end
    $display("test calibration done");
    rnd = lfsr(rnd);
    sfr_wr(`AGC_ADDR_INPUT_OFFSET_DAC, rnd[7:0]);
    @(posedge ref_clk);
    #1 `CHK("input_offset_dac sign", rnd[7], odacNegative)
    `CHK("input_offset_dac size", rnd[6:0], odacMagnitude)
    sfr_rd(`AGC_ADDR_INPUT_OFFSET_DAC, rd);
    `CHK("input_offset_dac read", rnd[7:0], rd)
    $display("test offset dac done");
    tally_and_finish();
  end
endmodule
